// ### hw/bsld_pkg.sv
// Purpose: Shared constants and types for the branch/skip/load decoder
// Assumes: 16-bit instruction words, 8-bit registers, word-addressed PC
// Notes: Instruction encodings below are this core's own format
// Behaviour
// RULE_01 - Compare-immediate subtracts, no store, sets Z N V C H, one clock
// RULE_02 - Skip-if-register-bit-clear skips next word(s), 1/2/3 clocks
// RULE_03 - Skip-if-register-bit-set skips next instruction when bit is one
// RULE_04 - Skip-if-I/O-bit-clear skips next instruction when bit reads zero
// RULE_05 - Skip-if-I/O-bit-set skips next instruction when I/O bit reads one
// RULE_06 - Branch-if-status-bit-set jumps PC+k+1 when bit set, 1 or 2 clocks
// RULE_07 - Branch-if-status-bit-clear jumps PC+k+1 when bit clear, 1/2 clocks
// RULE_08 - Carry branches jump on carry one or carry zero, flags untouched
// RULE_09 - Unsigned same-or-higher branch is the carry-zero branch
// RULE_10 - Signed at-least jumps when N xor V is zero; less-than when one
// RULE_11 - Half-carry branches jump on H one or H zero
// RULE_12 - Interrupts-on branch jumps PC+k+1 when I is one
// RULE_13 - Interrupts-off branch jumps PC+k+1 when I is zero
// RULE_14 - Post-increment load reads at pointer, then bumps it, two clocks
// RULE_15 - Pre-decrement load drops pointer first then reads, two clocks
// RULE_16 - Displacement load reads pointer plus q, pointer kept, two clocks
// RULE_17 - Register copy and pair copy take one clock, no flags
// RULE_18 - Load-constant takes one clock; plain pointer load takes two
package bsld_pkg;
  // ==========================================================
  // Opcodes, bits 15:12 of the instruction word
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000, OP_CMPI = 4'b0001, OP_LOADK = 4'b0010,
    OP_COPY = 4'b0011, OP_SKIP = 4'b0100, OP_BRSET = 4'b0101,
    OP_BRCLR = 4'b0110, OP_LDPTR = 4'b0111, OP_LDDISP = 4'b1000
  } bsld_op_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00, ST_STALL = 2'b01, ST_LOAD = 2'b10
  } bsld_state_t;
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } bsld_mem_req_t;
  // ==========================================================
  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 7;
  // Pointer pair low registers
  localparam logic [4:0] PTR_X = 5'h1a;
  localparam logic [4:0] PTR_Y = 5'h1c;
  localparam logic [4:0] PTR_Z = 5'h1e;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_PREDEC = 2'h2;
  // Extra stall cycles
  localparam logic [1:0] STALL_ONE = 2'h1;
  localparam logic [1:0] STALL_TWO = 2'h2;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_RF = 8'h80;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [15:0] RESET_PC = 16'h0000;
endpackage : bsld_pkg

// ### hw/bsld_core.sv
// Purpose: Executes compare, skip, branch, copy and load instructions
// Assumes: Memory answers memRdData in the cycle memReq.rd is high
// Notes: Register file and status flags live here; AHB-Lite for control
`timescale 1ns/10ps
module bsld_core
  import bsld_pkg::*;
(
  // Clock and reset
  input logic core_clk,
  input logic srst,
  // AHB-Lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Instruction fetch
  input logic instrValid,
  input logic [15:0] instrWord,
  input logic nextIsLong,
  output logic instrReady,
  output logic [15:0] pc,
  // I/O bit space and data memory
  input logic [255:0] ioSpace,
  output bsld_mem_req_t memReq,
  input logic [7:0] memRdData
);
  default clocking chkClk @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // ==========================================================
  // State
  logic [7:0] rf_q [0:31];
  bsld_state_t state_q, state_d;
  logic [1:0] stall_q, stall_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] flags_q;
  logic run_q, ready_q, wrPend_q;
  logic [7:0] wrAddr_q;
  logic [4:0] ldDest_q;
  bsld_mem_req_t mem_q;
  logic [31:0] hrdata_q;
  logic hready_q;

  function automatic logic [4:0] ptrBase(input logic [1:0] sel);
    ptrBase = (sel == 2'h0) ? PTR_X : (sel == 2'h1) ? PTR_Y : PTR_Z;
  endfunction : ptrBase

  // ==========================================================
  // Decode
  bsld_op_t op;
  logic accept, bitv, skipTake, flagv, brTake, isLoad;
  logic [4:0] dHi, base, sAddr;
  logic [7:0] kImm, rdv;
  logic [8:0] diff;
  logic [4:0] hdiff;
  logic [15:0] kExt, ptrVal, ptrNew, ldAddr;
  logic [1:0] mode;
  logic [7:0] cmpFlags;

  assign op = bsld_op_t'(instrWord[15:12]);
  assign accept = ready_q & instrValid;
  assign dHi = {1'b1, instrWord[11:8]};
  assign kImm = instrWord[7:0];
  assign rdv = rf_q[dHi];
  assign diff = {1'b0, rdv} - {1'b0, kImm};
  assign hdiff = {1'b0, rdv[3:0]} - {1'b0, kImm[3:0]};
  always_comb
  begin
    cmpFlags = flags_q;
    cmpFlags[FLAG_C] = diff[8]; // see RULE_01
    cmpFlags[FLAG_Z] = (diff[7:0] == 8'h00);
    cmpFlags[FLAG_N] = diff[7];
    cmpFlags[FLAG_V] = (rdv[7] ^ kImm[7]) & (rdv[7] ^ diff[7]);
    cmpFlags[FLAG_S] = diff[7] ^ cmpFlags[FLAG_V];
    cmpFlags[FLAG_H] = hdiff[4];
  end

  assign sAddr = instrWord[7:3];
  // Register form tests a general register, I/O form a bit of ioSpace
  assign bitv = instrWord[11] ? ioSpace[{sAddr, instrWord[2:0]}]
                              : rf_q[sAddr][instrWord[2:0]];
  assign skipTake = (bitv == instrWord[10]); // see RULE_02 see RULE_04

  // Carry, half carry and interrupt branches are bit aliases; signed ones test N xor V
  assign flagv = (instrWord[2:0] == FLAG_S)
               ? (flags_q[FLAG_N] ^ flags_q[FLAG_V]) // see RULE_10
               : flags_q[instrWord[2:0]]; // see RULE_08 see RULE_11
  assign brTake = (op == OP_BRSET) ? flagv : ~flagv; // see RULE_06
  assign kExt = {{9{instrWord[9]}}, instrWord[9:3]};

  assign mode = instrWord[9:8];
  assign base = (op == OP_LDDISP) ? (instrWord[11] ? PTR_Z : PTR_Y)
                                  : ptrBase(instrWord[11:10]);
  assign ptrVal = {rf_q[base + 5'h01], rf_q[base]};
  assign ptrNew = (mode == MODE_PREDEC) ? ptrVal - 16'h0001
                                        : ptrVal + 16'h0001;
  always_comb
  begin
    ldAddr = ptrVal; // see RULE_14
    if (op == OP_LDDISP)
      ldAddr = ptrVal + {10'h000, instrWord[10:5]}; // see RULE_16
    else if (mode == MODE_PREDEC)
      ldAddr = ptrNew; // see RULE_15
  end
  assign isLoad = (op == OP_LDPTR) | (op == OP_LDDISP);

  // ==========================================================
  // Next PC, stall length and state
  always_comb
  begin
    pc_d = pc_q;
    stall_d = stall_q;
    state_d = state_q;
    case (state_q)
      ST_RUN:
      begin
        if (accept)
        begin
          pc_d = pc_q + 16'h0001;
          if (op == OP_SKIP && skipTake)
          begin
            // see RULE_03 see RULE_05
            pc_d = pc_q + (nextIsLong ? 16'h0003 : 16'h0002);
            stall_d = nextIsLong ? STALL_TWO : STALL_ONE;
            state_d = ST_STALL;
          end
          else if ((op == OP_BRSET || op == OP_BRCLR) && brTake)
          begin
            // see RULE_07 see RULE_09 see RULE_12 see RULE_13
            pc_d = pc_q + kExt + 16'h0001;
            stall_d = STALL_ONE;
            state_d = ST_STALL;
          end
          else if (isLoad)
            state_d = ST_LOAD; // see RULE_18
        end
      end
      ST_STALL:
      begin
        stall_d = stall_q - 2'h1;
        if (stall_q == STALL_ONE)
          state_d = ST_RUN;
      end
      ST_LOAD: state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_q <= ST_RUN;
      stall_q <= 2'h0;
      pc_q <= RESET_PC;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      stall_q <= stall_d;
      pc_q <= pc_d;
      // Halting only blocks new instructions, never one in flight
      ready_q <= run_q & (state_d == ST_RUN);
    end
  end

  // ==========================================================
  // Register file
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 32; i++)
        rf_q[i] <= 8'h00;
    end
    else if (state_q == ST_LOAD)
      rf_q[ldDest_q] <= memRdData; // see RULE_14
    else if (accept)
    begin
      case (op)
        OP_LOADK: rf_q[dHi] <= kImm; // see RULE_18
        OP_COPY:
          if (instrWord[11:10] == 2'h0)
            rf_q[instrWord[9:5]] <= rf_q[instrWord[4:0]]; // see RULE_17
          else
          begin
            rf_q[{instrWord[7:4], 1'b0}] <= rf_q[{instrWord[3:0], 1'b0}];
            rf_q[{instrWord[7:4], 1'b1}] <= rf_q[{instrWord[3:0], 1'b1}];
          end
        OP_LDPTR:
          if (mode == MODE_POSTINC || mode == MODE_PREDEC)
          begin
            rf_q[base] <= ptrNew[7:0]; // see RULE_14 see RULE_15
            rf_q[base + 5'h01] <= ptrNew[15:8];
          end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Memory request
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      mem_q <= '0;
      ldDest_q <= 5'h00;
    end
    else
    begin
      mem_q.rd <= accept & isLoad;
      if (accept & isLoad)
      begin
        mem_q.addr <= ldAddr;
        ldDest_q <= (op == OP_LDDISP) ? instrWord[4:0] : instrWord[7:3];
      end
    end
  end

  // ==========================================================
  // Flags; a compare in the same cycle beats a software write
  always_ff @(posedge core_clk)
  begin
    if (srst)
      flags_q <= RESET_FLAGS;
    else if (accept && op == OP_CMPI)
      flags_q <= cmpFlags; // see RULE_01
    else if (wrPend_q && wrAddr_q == ADDR_FLAGS)
      flags_q <= hwdata[7:0];
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  logic aPhase;
  assign aPhase = hsel & htrans[1] & hready;
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
      run_q <= 1'b0;
    end
    else
    begin
      hready_q <= 1'b1;
      wrPend_q <= aPhase & hwrite;
      wrAddr_q <= haddr[7:0];
      if (wrPend_q && wrAddr_q == ADDR_CTRL)
        run_q <= hwdata[0];
      hrdata_q <= 32'h0000_0000;
      if (aPhase && !hwrite && haddr[31:8] == 24'h00_0000)
      begin
        if (haddr[7:0] == ADDR_CTRL)
          hrdata_q <= {31'h0000_0000, run_q};
        else if (haddr[7:0] == ADDR_FLAGS)
          hrdata_q <= {24'h00_0000, flags_q};
        else if (haddr[7:0] == ADDR_PC)
          hrdata_q <= {16'h0000, pc_q};
        else if (haddr[7] && haddr[1:0] == 2'h0)
          hrdata_q <= {24'h00_0000, rf_q[haddr[6:2]]};
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = 1'b0 & hready_q;
  assign instrReady = ready_q;
  assign pc = pc_q;
  assign memReq = mem_q;

  // ==========================================================
  // Checks
  chk_cmp_one_clock: assert property ( // see RULE_01
    accept && op == OP_CMPI |=> ready_q)
    else $error("compare did not finish in one clock");
  chk_cmp_zero_flag: assert property ( // see RULE_01
    accept && op == OP_CMPI |=> flags_q[FLAG_Z] == $past(rdv == kImm))
    else $error("compare zero flag wrong");
  chk_skip_short: assert property ( // see RULE_02
    accept && op == OP_SKIP && skipTake && !nextIsLong
    |=> pc_q == $past(pc_q) + 16'h0002 && !ready_q ##1 ready_q)
    else $error("short skip wrong");
  chk_skip_long: assert property ( // see RULE_03
    accept && op == OP_SKIP && skipTake && nextIsLong
    |=> pc_q == $past(pc_q) + 16'h0003 ##1 !ready_q ##1 ready_q)
    else $error("long skip wrong");
  chk_skip_none: assert property ( // see RULE_04
    accept && op == OP_SKIP && !skipTake
    |=> pc_q == $past(pc_q) + 16'h0001 && ready_q)
    else $error("untaken skip wrong");
  chk_branch_taken: assert property ( // see RULE_06
    accept && (op == OP_BRSET || op == OP_BRCLR) && brTake
    |=> pc_q == $past(pc_q) + $past(kExt) + 16'h0001 && !ready_q
    ##1 ready_q) else $error("taken branch wrong");
  chk_branch_fall: assert property ( // see RULE_07
    accept && (op == OP_BRSET || op == OP_BRCLR) && !brTake
    |=> pc_q == $past(pc_q) + 16'h0001 && ready_q)
    else $error("untaken branch wrong");
  chk_load_two: assert property ( // see RULE_14
    accept && isLoad |=> mem_q.rd && mem_q.addr == $past(ldAddr)
    && !ready_q ##1 !mem_q.rd) else $error("load timing");
  chk_predec_addr: assert property ( // see RULE_15
    accept && op == OP_LDPTR && mode == MODE_PREDEC
    |=> mem_q.addr == $past(ptrVal) - 16'h0001)
    else $error("pre-decrement address wrong");
  chk_disp_addr: assert property ( // see RULE_16
    accept && op == OP_LDDISP
    |=> mem_q.addr == $past(ptrVal) + {10'h000, $past(instrWord[10:5])})
    else $error("displacement address wrong");
  chk_loadk_value: assert property ( // see RULE_18
    accept && op == OP_LOADK |=> rf_q[$past(dHi)] == $past(kImm) && ready_q)
    else $error("load constant wrong");
  cov_branch: cover property (@(posedge core_clk)
    accept && op == OP_BRCLR && brTake);
  cov_skip_long: cover property (@(posedge core_clk)
    accept && op == OP_SKIP && skipTake && nextIsLong);
  cov_postinc: cover property (@(posedge core_clk)
    accept && op == OP_LDPTR && mode == MODE_POSTINC);
  cov_cmp: cover property (@(posedge core_clk) accept && op == OP_CMPI);
endmodule : bsld_core

// ### tb/bsld_mem_model.sv
// Purpose: Combinational data memory on the far side of the load port
// Assumes: The byte at an address is a fixed function of that address
// Notes: Outside a read the bus shows the inverse, never a stale byte
`timescale 1ns/10ps
module bsld_mem_model
  import bsld_pkg::*;
(
  // Load port
  input bsld_mem_req_t memReq,
  output logic [7:0] memRdData
);
  // ==========================================================
  // Read path
  logic [7:0] cellByte;
  assign cellByte = memReq.addr[7:0] ^ memReq.addr[15:8] ^ 8'h5A;
  always_comb
  begin
    if (memReq.rd === 1'b1)
      memRdData = cellByte;
    else
      memRdData = ~cellByte;
  end
endmodule : bsld_mem_model

// ### tb/test_branch_skip_load_decoder.sv
// Purpose: Self-checking bench for the branch/skip/load core
// Assumes: One AHB-Lite slave; bench plays fetch, model plays memory
// Notes: Outputs read right after an edge hold the value seen at it
`timescale 1ns/10ps
module test_branch_skip_load_decoder
  import bsld_pkg::*;
;
  // ==========================================================
  // Signals
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic instrValid = 1'b0;
  logic nextIsLong = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  // Only I/O bit 5.3 is one
  logic [255:0] ioSpace = 256'h800_0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic instrReady;
  logic [15:0] pc;
  logic [15:0] epc = 16'h0000;
  bsld_mem_req_t memReq;
  logic [7:0] memRdData;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 core_clk = ~core_clk;
  // ==========================================================
  // Design and memory
  bsld_core bsld_core_i (.core_clk(core_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .instrValid(instrValid),
    .instrWord(instrWord), .nextIsLong(nextIsLong),
    .instrReady(instrReady), .pc(pc), .ioSpace(ioSpace),
    .memReq(memReq), .memRdData(memRdData));
  bsld_mem_model bsld_mem_model_i (.memReq(memReq),
    .memRdData(memRdData));
  // ==========================================================
  // Tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Single AHB transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input string what, input logic [31:0] a,
    input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    chk(what, exp, x & m);
  endtask : rdc
  function automatic logic [31:0] ra(input int n);
    return 32'(ADDR_RF) + 32'(4 * n);
  endfunction : ra
  function automatic logic [31:0] mb(input logic [15:0] a);
    return {24'h00_0000, a[7:0] ^ a[15:8] ^ 8'h5A};
  endfunction : mb
  // Issue one word, count clocks until fetch is ready again
  task automatic run(input logic [15:0] w, input logic lng, input int clk,
    input logic [15:0] dl);
    int n;
    instrValid <= 1'b1;
    instrWord <= w;
    nextIsLong <= lng;
    @(posedge core_clk);
    while (instrReady !== 1'b1) @(posedge core_clk);
    instrValid <= 1'b0;
    n = 1;
    @(posedge core_clk);
    while (instrReady !== 1'b1 && n < 9)
    begin
      n++;
      @(posedge core_clk);
    end
    epc = epc + dl;
    chk("clocks", 32'(clk), 32'(n));
    chk("pc", {16'h0000, epc}, {16'h0000, pc});
  endtask : run
  // ==========================================================
  // Hang guard; the whole run needs about 250 cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end
  // ==========================================================
  // Tests
  initial
  begin
    logic [7:0] fl;
    logic [6:0] k;
    logic tk;
    logic [15:0] w;
    logic [15:0] dl;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rdc("flags", 32'(ADDR_FLAGS), 32'(RESET_FLAGS), 32'h0000_00FF);
    wr(32'h0000_0040, 32'h0000_00FF);
    rdc("unmapped", 32'h0000_0040, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(32'(ADDR_PC), 32'h0000_1234);
    rdc("pc ro", 32'(ADDR_PC), 32'(RESET_PC), 32'hFFFF_FFFF);
    $display("test reset done");
    // Held while stopped: nothing may be taken
    instrValid <= 1'b1;
    instrWord <= 16'h2080;
    repeat (4) @(posedge core_clk);
    chk("pc stopped", 32'h0000_0000, {16'h0000, pc});
    wr(32'(ADDR_CTRL), 32'h0000_0001);
    run(16'h2080, 1'b0, 1, 16'h0001);
    run(16'h2111, 1'b0, 1, 16'h0001);
    run(16'h3030, 1'b0, 1, 16'h0001);
    run(16'h3418, 1'b0, 1, 16'h0001);
    rdc("r1", ra(1), 32'h0000_0080, 32'h0000_00FF);
    rdc("r2", ra(2), 32'h0000_0080, 32'h0000_00FF);
    rdc("r3", ra(3), 32'h0000_0011, 32'h0000_00FF);
    $display("test copy done");
    run(16'h1001, 1'b0, 1, 16'h0001);
    rdc("cmp 01", 32'(ADDR_FLAGS), 32'h28, 32'h2F);
    run(16'h1080, 1'b0, 1, 16'h0001);
    rdc("cmp 80", 32'(ADDR_FLAGS), 32'h02, 32'h2F);
    run(16'h1081, 1'b0, 1, 16'h0001);
    rdc("cmp 81", 32'(ADDR_FLAGS), 32'h25, 32'h2F);
    rdc("r16", ra(16), 32'h0000_0080, 32'h0000_00FF);
    $display("test compare done");
    // Patterns differ on N xor V against the stored S bit
    for (int p = 0; p < 2; p++)
    begin
      fl = p ? 8'h52 : 8'hA9;
      wr(32'(ADDR_FLAGS), {24'h00_0000, fl});
      for (int i = 0; i < 16; i++)
      begin
        k = i[0] ? 7'h7D : 7'h05;
        tk = (i[2:0] == 3'h4) ? fl[2] ^ fl[3] : fl[i[2:0]];
        tk = tk ^ i[3];
        w = {i[3] ? 4'h6 : 4'h5, 2'b00, k, i[2:0]};
        dl = tk ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001;
        run(w, 1'b0, tk ? 2 : 1, dl);
      end
      rdc("br flags", 32'(ADDR_FLAGS), {24'h0, fl}, 32'hFF);
    end
    $display("test branch done");
    for (int i = 0; i < 16; i++)
    begin
      tk = i[1] == i[2];
      w = {4'h4, i[3], i[2], 2'b00, i[3] ? 5'h05 : 5'h10, 3'h0};
      w[2:0] = i[3] ? {2'b01, i[1]} : {3{i[1]}};
      dl = tk ? (i[0] ? 16'h0003 : 16'h0002) : 16'h0001;
      run(w, i[0], 32'(dl), dl);
    end
    rdc("sk flags", 32'(ADDR_FLAGS), 32'h52, 32'hFF);
    $display("test skip done");
    // Pointer steps cross the byte boundary both ways
    run(16'h2E00, 1'b0, 1, 16'h0001);
    run(16'h2F02, 1'b0, 1, 16'h0001);
    run(16'h7A30, 1'b0, 2, 16'h0001);
    rdc("r6", ra(6), mb(16'h01FF), 32'hFF);
    rdc("zl dec", ra(30), 32'hFF, 32'hFF);
    rdc("zh dec", ra(31), 32'h01, 32'hFF);
    run(16'h7928, 1'b0, 2, 16'h0001);
    rdc("r5", ra(5), mb(16'h01FF), 32'hFF);
    rdc("zl inc", ra(30), 32'h00, 32'hFF);
    rdc("zh inc", ra(31), 32'h02, 32'hFF);
    run(16'h7838, 1'b0, 2, 16'h0001);
    rdc("r7", ra(7), mb(16'h0200), 32'hFF);
    run(16'h8FE8, 1'b0, 2, 16'h0001);
    rdc("r8", ra(8), mb(16'h023F), 32'hFF);
    rdc("zl disp", ra(30), 32'h00, 32'hFF);
    // Y with displacement and X with post-increment
    run(16'h2C10, 1'b0, 1, 16'h0001);
    run(16'h2D03, 1'b0, 1, 16'h0001);
    run(16'h8029, 1'b0, 2, 16'h0001);
    rdc("r9", ra(9), mb(16'h0311), 32'hFF);
    rdc("yl disp", ra(28), 32'h10, 32'hFF);
    run(16'h2AFF, 1'b0, 1, 16'h0001);
    run(16'h2B00, 1'b0, 1, 16'h0001);
    run(16'h7150, 1'b0, 2, 16'h0001);
    rdc("r10", ra(10), mb(16'h00FF), 32'hFF);
    rdc("xl inc", ra(26), 32'h00, 32'hFF);
    rdc("xh inc", ra(27), 32'h01, 32'hFF);
    $display("test load done");
    wrap_up();
  end
endmodule : test_branch_skip_load_decoder
